//--- hw/dpsc_decoder.sv
// Functional notes
// - Write command loads 10-bit data into the addressed channel wiper.
// - Increment command adds one to the channel 1 wiper per frame below full scale.
// - Store command copies the addressed channel wiper into its nonvolatile slot.
// - Write-protect low blocks every nonvolatile memory change.
// - Restore command reloads channel 1 wiper from nonvolatile memory.
// - Power-on and preset strobe reload both wipers from nonvolatile memory.
// - No-operation changes nothing, shifts pending word, returns to idle.
// - Shift-left command doubles the addressed channel wiper.
// - Doubling beyond ten bits clamps at full scale.
// - User-store writes 16 data bits to the addressed user location.
// - Nonvolatile read returns command, address and stored word next frame.
// - Wiper read returns addressed wiper in low bits next frame.
// - Each frame shifts out previous frame, or read data when prepared.
// - Each wiper holds a 10-bit code, zero at the B end.
// - Restore leaves read-mode power until a following no-operation.
module dpsc_decoder (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Serial pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  // Control pins, active low
  input wire logic i_wp_n,
  input wire logic i_preset_restore_n,
  // Wiper codes and power state
  output logic [9:0] o_wiper_terminal_ch1,
  output logic [9:0] o_wiper_terminal_ch2,
  output logic o_read_mode
);

  dpsc_pkg::dpsc_frame_t frame;
  dpsc_pkg::dpsc_frame_t tx_word_reg;
  logic frame_vld;
  logic [15:0] nonvolatile_store [dpsc_pkg::NV_LOCS];
  logic [9:0] wiper_setting_ch1;
  logic [9:0] wiper_setting_ch2;
  logic [1:0] wp_sync_reg;
  logic [1:0] pr_sync_reg;
  logic pr_d_reg;
  logic por_reg;
  logic preset_evt;
  logic nv_wr_ok;
  logic [10:0] dbl1;
  logic [10:0] dbl2;

  assign wiper_setting_ch1 = o_wiper_terminal_ch1;
  assign wiper_setting_ch2 = o_wiper_terminal_ch2;
  assign dbl1 = {wiper_setting_ch1, 1'b0};
  assign dbl2 = {wiper_setting_ch2, 1'b0};

  ////////////////////////////////////////////////////////////////////////
  // Serial front end
  dpsc_spi_rx u_rx (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_sdi(i_sdi),
    .i_tx_word(tx_word_reg),
    .o_frame_vld(frame_vld),
    .o_frame(frame),
    .o_sdo(o_sdo)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and preset strobe detection
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wp_sync_reg <= 2'h0;
      pr_sync_reg <= 2'h3;
      pr_d_reg <= 1'b1;
      por_reg <= 1'b1;
    end else begin
      wp_sync_reg <= {wp_sync_reg[0], i_wp_n};
      pr_sync_reg <= {pr_sync_reg[0], i_preset_restore_n};
      pr_d_reg <= pr_sync_reg[1];
      por_reg <= 1'b0;
    end
  end

  assign preset_evt = por_reg || (pr_d_reg && !pr_sync_reg[1]);
  assign nv_wr_ok = frame_vld && wp_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // Nonvolatile locations, one generate entry each
  for (genvar g = 0; g < dpsc_pkg::NV_LOCS; g++) begin : g_nv
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        nonvolatile_store[g] <= dpsc_pkg::NV_RESET;
      end else if (nv_wr_ok && frame.addr == 4'(g)) begin
        if (frame.cmd == dpsc_pkg::CMD_STORE && g <= 1) begin
          nonvolatile_store[g] <= {6'h00, (g == 0) ? wiper_setting_ch1
                                                   : wiper_setting_ch2};
        end else if (frame.cmd == dpsc_pkg::CMD_USER_STORE &&
                     4'(g) >= dpsc_pkg::ADDR_USER_FIRST &&
                     4'(g) <= dpsc_pkg::ADDR_USER_LAST) begin
          nonvolatile_store[g] <= frame.data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wiper channel 1
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_wiper_terminal_ch1 <= 10'h000;
    end else if (preset_evt) begin
      o_wiper_terminal_ch1 <= nonvolatile_store[0][9:0];
    end else if (frame_vld && frame.addr == dpsc_pkg::ADDR_CH1) begin
      unique case (frame.cmd)
        dpsc_pkg::CMD_WRITE: o_wiper_terminal_ch1 <= frame.data[9:0];
        dpsc_pkg::CMD_INC: begin
          if (wiper_setting_ch1 != dpsc_pkg::WIPER_FULL) begin
            o_wiper_terminal_ch1 <= wiper_setting_ch1 + 10'h001;
          end
        end
        dpsc_pkg::CMD_RESTORE: o_wiper_terminal_ch1 <= nonvolatile_store[0][9:0];
        dpsc_pkg::CMD_SHIFT_LEFT: begin
          o_wiper_terminal_ch1 <= dbl1[10] ? dpsc_pkg::WIPER_FULL : dbl1[9:0];
        end
        default: ;
      endcase
    end
  end

  // Wiper channel 2
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_wiper_terminal_ch2 <= 10'h000;
    end else if (preset_evt) begin
      o_wiper_terminal_ch2 <= nonvolatile_store[1][9:0];
    end else if (frame_vld && frame.addr == dpsc_pkg::ADDR_CH2) begin
      unique case (frame.cmd)
        dpsc_pkg::CMD_WRITE: o_wiper_terminal_ch2 <= frame.data[9:0];
        dpsc_pkg::CMD_SHIFT_LEFT: begin
          o_wiper_terminal_ch2 <= dbl2[10] ? dpsc_pkg::WIPER_FULL : dbl2[9:0];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next outgoing word: echo, or read data in the low 16 bits
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tx_word_reg <= dpsc_pkg::OUT_RESET;
    end else if (frame_vld) begin
      tx_word_reg <= frame;
      if (frame.cmd == dpsc_pkg::CMD_NV_READ) begin
        tx_word_reg.data <= nonvolatile_store[frame.addr];
      end else if (frame.cmd == dpsc_pkg::CMD_WIPER_READ) begin
        tx_word_reg.data <= {6'h00, (frame.addr == dpsc_pkg::ADDR_CH2)
                             ? wiper_setting_ch2 : wiper_setting_ch1};
      end
    end
  end

  // Read-mode power state
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_read_mode <= 1'b0;
    end else if (frame_vld && frame.cmd == dpsc_pkg::CMD_RESTORE) begin
      o_read_mode <= 1'b1;
    end else if (frame_vld && frame.cmd == dpsc_pkg::CMD_NOP) begin
      o_read_mode <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_nv_protect: assert property (@(posedge i_mclk) disable iff (i_rst)
    frame_vld && !wp_sync_reg[1] |=> $stable(nonvolatile_store[0]))
    else $error("nonvolatile word changed while protected");
  a_inc_sat: assert property (@(posedge i_mclk) disable iff (i_rst)
    frame_vld && !preset_evt && frame.cmd == dpsc_pkg::CMD_INC && frame.addr == 4'h0
    |=> o_wiper_terminal_ch1 == (($past(o_wiper_terminal_ch1) == 10'h3FF) ? 10'h3FF
        : $past(o_wiper_terminal_ch1) + 10'h001))
    else $error("increment result wrong");
  a_shift_clamp: assert property (@(posedge i_mclk) disable iff (i_rst)
    frame_vld && !preset_evt && frame.cmd == dpsc_pkg::CMD_SHIFT_LEFT && frame.addr == 4'h0
    && o_wiper_terminal_ch1[9] |=> o_wiper_terminal_ch1 == 10'h3FF)
    else $error("doubling did not clamp");
  a_echo_word: assert property (@(posedge i_mclk) disable iff (i_rst)
    frame_vld |=> tx_word_reg[23:16] == $past(frame[23:16]))
    else $error("echo header wrong");
  a_restore_mode: assert property (@(posedge i_mclk) disable iff (i_rst)
    frame_vld && frame.cmd == dpsc_pkg::CMD_RESTORE |=> o_read_mode)
    else $error("read mode not entered");
  a_write_ch2: assert property (@(posedge i_mclk) disable iff (i_rst)
    frame_vld && !preset_evt && frame.cmd == dpsc_pkg::CMD_WRITE
    && frame.addr == dpsc_pkg::ADDR_CH2 |=> o_wiper_terminal_ch2 == $past(frame.data[9:0]))
    else $error("channel 2 write not loaded");
  a_restore_load: assert property (@(posedge i_mclk) disable iff (i_rst)
    frame_vld && !preset_evt && frame.cmd == dpsc_pkg::CMD_RESTORE
    && frame.addr == dpsc_pkg::ADDR_CH1
    |=> o_wiper_terminal_ch1 == $past(nonvolatile_store[0][9:0]))
    else $error("restore did not reload channel 1");
  a_nop_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    frame_vld && !preset_evt && frame.cmd == dpsc_pkg::CMD_NOP
    |=> $stable(o_wiper_terminal_ch1) && $stable(o_wiper_terminal_ch2) && !o_read_mode)
    else $error("no-operation changed state");
  a_preset_load: assert property (@(posedge i_mclk) disable iff (i_rst)
    preset_evt |=> o_wiper_terminal_ch1 == $past(nonvolatile_store[0][9:0])
    && o_wiper_terminal_ch2 == $past(nonvolatile_store[1][9:0]))
    else $error("preset did not reload wipers");
  a_wiper_read: assert property (@(posedge i_mclk) disable iff (i_rst)
    frame_vld && frame.cmd == dpsc_pkg::CMD_WIPER_READ && frame.addr == dpsc_pkg::ADDR_CH1
    |=> tx_word_reg.data == {6'h00, $past(o_wiper_terminal_ch1)})
    else $error("wiper readback word wrong");
  a_user_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    nv_wr_ok && frame.cmd == dpsc_pkg::CMD_USER_STORE
    && frame.addr == dpsc_pkg::ADDR_USER_FIRST
    |=> nonvolatile_store[2] == $past(frame.data))
    else $error("user word not stored");

endmodule : dpsc_decoder

//--- hw/dpsc_pkg.sv
package dpsc_pkg;

  // Frame and field widths
  localparam int FRAME_BITS = 24;
  localparam int WIPER_BITS = 10;
  localparam int DATA_BITS = 16;
  localparam int NV_LOCS = 16;

  // Command nibbles
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RESTORE = 4'h1;
  localparam logic [3:0] CMD_STORE = 4'h2;
  localparam logic [3:0] CMD_USER_STORE = 4'h3;
  localparam logic [3:0] CMD_NV_READ = 4'h9;
  localparam logic [3:0] CMD_WIPER_READ = 4'hA;
  localparam logic [3:0] CMD_WRITE = 4'hB;
  localparam logic [3:0] CMD_SHIFT_LEFT = 4'hC;
  localparam logic [3:0] CMD_INC = 4'hE;

  // Locations and reset values
  localparam logic [3:0] ADDR_CH1 = 4'h0;
  localparam logic [3:0] ADDR_CH2 = 4'h1;
  localparam logic [3:0] ADDR_USER_FIRST = 4'h2;
  localparam logic [3:0] ADDR_USER_LAST = 4'hE;
  localparam logic [9:0] WIPER_FULL = 10'h3FF;
  localparam logic [15:0] NV_RESET = 16'h0200;
  localparam logic [23:0] OUT_RESET = 24'h000000;

  // One command word
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } dpsc_frame_t;

endpackage : dpsc_pkg

//--- hw/dpsc_spi_rx.sv
// Samples the serial pins, shifts frames in and out
module dpsc_spi_rx (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Serial pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  // Word to shift out, loaded at frame start
  input wire dpsc_pkg::dpsc_frame_t i_tx_word,
  // Received frame
  output logic o_frame_vld,
  output dpsc_pkg::dpsc_frame_t o_frame,
  output logic o_sdo
);

  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic sclk_d_reg;
  logic cs_d_reg;
  logic [23:0] rx_reg;
  logic [23:0] tx_reg;
  logic [4:0] cnt_reg;

  // Two-stage synchronisers on sclk, cs_n, sdi
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_reg <= 3'h4; // Idle levels: cs_n high, sclk low, no false edge
      s2_reg <= 3'h4;
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else begin
      s1_reg <= {i_cs_n, i_sclk, i_sdi};
      s2_reg <= s1_reg;
      sclk_d_reg <= s2_reg[1];
      cs_d_reg <= s2_reg[2];
    end
  end

  // Shift on rising sclk, change sdo on falling, close at cs_n rise
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rx_reg <= 24'h000000;
      tx_reg <= dpsc_pkg::OUT_RESET;
      cnt_reg <= 5'h00;
      o_frame_vld <= 1'b0;
      o_frame <= '0;
      o_sdo <= 1'b0;
    end else begin
      o_frame_vld <= 1'b0;
      if (cs_d_reg && !s2_reg[2]) begin
        tx_reg <= i_tx_word;
        o_sdo <= i_tx_word[23];
        cnt_reg <= 5'h00;
      end else if (!s2_reg[2] && s2_reg[1] && !sclk_d_reg) begin
        rx_reg <= {rx_reg[22:0], s2_reg[0]};
        if (cnt_reg != 5'h1F) cnt_reg <= cnt_reg + 5'h01;
      end else if (!s2_reg[2] && !s2_reg[1] && sclk_d_reg) begin
        tx_reg <= {tx_reg[22:0], 1'b0};
        o_sdo <= tx_reg[22];
      end else if (!cs_d_reg && s2_reg[2]) begin
        o_frame_vld <= (cnt_reg == 5'(dpsc_pkg::FRAME_BITS));
        o_frame <= rx_reg;
      end
    end
  end

endmodule : dpsc_spi_rx

//--- testbench/dpsc_spi_host.sv
// Host side of the serial link, mode 0, MSB first
module dpsc_spi_host (
  // Clock
  input wire logic i_mclk,
  // Serial pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 1ns;

  // Half of the 800 ns link clock
  localparam int HALF = 4;

  // Link idle, clock stands low
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end

  // Wait some master clocks
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : idle

  // One 24-bit frame; returns what came back
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    @(posedge i_mclk);
    o_cs_n <= 1'b0;
    o_sdi <= w[23];
    idle(2 * HALF);
    for (int i = 23; i >= 0; i--) begin
      o_sdi <= w[i];
      idle(HALF);
      o_sclk <= 1'b1;
      idle(2);
      r[i] = i_sdo;
      idle(HALF - 2);
      o_sclk <= 1'b0;
    end
    idle(HALF);
    o_cs_n <= 1'b1;
    o_sdi <= ~w[0]; // Released line shows no stale bit
    idle(16);
  endtask : xfer
endmodule : dpsc_spi_host

//--- testbench/tb_dpsc_decoder.sv
// Self-checking bench for the command decoder
module tb_dpsc_decoder;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_mclk;
  logic i_rst;
  logic i_wp_n;
  logic i_preset_restore_n;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic read_mode;
  logic [9:0] w1;
  logic [9:0] w2;
  logic [23:0] rx;
  int n_errors = 0;
  int comparisons = 0;

  ////////////////////////////////////////////////
  dpsc_decoder DUT (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .o_sdo(sdo), .i_wp_n(i_wp_n),
    .i_preset_restore_n(i_preset_restore_n), .o_wiper_terminal_ch1(w1),
    .o_wiper_terminal_ch2(w2), .o_read_mode(read_mode)
  );
  dpsc_spi_host host (
    .i_mclk(i_mclk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo)
  );

  // 10 MHz master clock
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One frame through the host
  task automatic fr(input logic [23:0] w);
    host.xfer(w, rx);
  endtask : fr

  // Verdict and stop
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////
  // Writes, increments, store and restore
  task automatic t_write_store();
    fr(24'hB00100);
    fr(24'hB10155);
    check(rx, 24'hB00100);
    check({14'h0, w1}, 24'h000100);
    check({14'h0, w2}, 24'h000155);
    fr(24'hE00000);
    fr(24'hE00000);
    check(rx, 24'hE00000);
    check({14'h0, w1}, 24'h000102);
    fr(24'h200000);
    fr(24'hB00050);
    fr(24'h100000);
    check({14'h0, w1}, 24'h000102);
    check({23'h0, read_mode}, 24'h000001);
    fr(24'h000000);
    check(rx, 24'h100000);
    check({23'h0, read_mode}, 24'h000000);
    check({14'h0, w1}, 24'h000102);
  endtask : t_write_store

  // Protected store is refused
  task automatic t_protect();
    @(posedge i_mclk);
    i_wp_n <= 1'b0;
    fr(24'hB00050);
    fr(24'h200000);
    fr(24'h100000);
    fr(24'h000000);
    check({14'h0, w1}, 24'h000102);
    @(posedge i_mclk);
    i_wp_n <= 1'b1;
  endtask : t_protect

  // Doubling, clamp, wiper readback, saturation
  task automatic t_shift();
    fr(24'hB00200);
    fr(24'hC00000);
    check({14'h0, w1}, 24'h0003FF);
    fr(24'hA00000);
    fr(24'hB10011);
    check(rx, 24'hA003FF);
    fr(24'hC10000);
    check({14'h0, w2}, 24'h000022);
    fr(24'hE00000);
    check({14'h0, w1}, 24'h0003FF);
  endtask : t_shift

  // User words stored and read back
  task automatic t_user();
    fr(24'h32AAAA);
    fr(24'h335555);
    fr(24'h920000);
    fr(24'h930000);
    check(rx, 24'h92AAAA);
    fr(24'h000000);
    check(rx, 24'h935555);
  endtask : t_user

  // Preset strobe reloads both wipers
  task automatic t_preset();
    fr(24'hB00001);
    @(posedge i_mclk);
    i_preset_restore_n <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_preset_restore_n <= 1'b1;
    repeat (8) @(posedge i_mclk);
    check({14'h0, w1}, 24'h000102);
    check({14'h0, w2}, 24'h000200);
  endtask : t_preset

  ////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_rst = 1'b1;
    i_wp_n = 1'b1;
    i_preset_restore_n = 1'b1;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_mclk);
    check({w1, w2, 4'h0}, 24'h802000);
    t_write_store();
    t_protect();
    t_shift();
    t_user();
    t_preset();
    end_sim();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    end_sim();
  end
endmodule : tb_dpsc_decoder
